// ---- design/sar_ctrl_pkg.sv ----
// Constants and types shared by the converter control design
package sar_ctrl_pkg;
	localparam int NUM_CHANNELS = 24;
	localparam int RESULT_WIDTH = 16;
	localparam int MAX_RESOLUTION = 12;
	localparam int NUM_TRIG_SOURCES = 8;
	localparam int TRIG_SEL_WIDTH = 3;
	localparam int NUM_COMPARATORS = 4;
	localparam int NUM_FILTERS = 4;
	localparam int NUM_CORES = 3;
	localparam int DEDICATED_CH0 = 0;
	localparam int DEDICATED_CH1 = 1;
	localparam int FILTER_LOG2_SAMPLES = 2;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [3:0] RES_RESET = 4'hC;
	localparam logic [2:0] TRIG_RESET = 3'h0;

	// Trigger source codes
	localparam logic [2:0] TRIG_NONE = 3'h0;
	localparam logic [2:0] TRIG_SOFTWARE = 3'h1;
	localparam logic [2:0] TRIG_PWM = 3'h2;
	localparam logic [2:0] TRIG_MULTI_TIMER = 3'h3;
	localparam logic [2:0] TRIG_SINGLE_TIMER = 3'h4;
	localparam logic [2:0] TRIG_LOGIC_CELL = 3'h5;
	localparam logic [2:0] TRIG_EXT_PIN = 3'h6;

	// Comparator modes
	typedef enum logic [1:0] {
		CMP_ABOVE = 2'h0,
		CMP_BELOW = 2'h1,
		CMP_INSIDE = 2'h2,
		CMP_OUTSIDE = 2'h3
	} cmp_mode_t;

	// Shared core sequencer states
	typedef enum logic [1:0] {
		SH_IDLE = 2'b01,
		SH_BUSY = 2'b10
	} shared_state_t;
endpackage

// ---- design/sar_result_format.sv ----
// Result formatting: resolution alignment and signed/unsigned output
module sar_result_format (
	// Raw conversion
	input wire logic [11:0] rawData,
	input wire logic [3:0] resolution,
	// Channel settings
	input wire logic signedFormat,
	input wire logic differential,
	// Formatted result
	output logic [15:0] formatted
);
	logic [11:0] trimmed;
	logic [15:0] unsignedValue;

	// Drop low bits beyond the selected resolution, max 12 bits
	always_comb begin
		if (resolution >= 4'hC) begin
			trimmed = rawData;
		end else begin
			trimmed = rawData & ~(12'hFFF >> resolution);
		end
		unsignedValue = {4'h0, trimmed};
		// Signed: offset-binary to two's complement, sign extended
		if (signedFormat || differential) begin
			formatted = {{4{~trimmed[11]}}, ~trimmed[11], trimmed[10:0]};
		end else begin
			formatted = unsignedValue;
		end
	end
endmodule

// ---- design/multi_sar_adc_control.sv ----
// Trigger, sequencing, result and post-processing control for a three-core converter
// Functional notes
// [RL1] Three cores: two dedicated to fixed inputs, one shared by all others.
// [RL2] Each core has a software-selected resolution of at most 12 bits.
// [RL3] Up to 24 channels, each with its own 16-bit result register.
// [RL4] Each channel individually selects unsigned or signed result format.
// [RL5] Up to three inputs sampled at once, one per core.
// [RL6] Shared-core requests are converted in order, lowest input number first.
// [RL7] Each input selects its own trigger source.
// [RL8] Sources: PWM, timers, logic cell, external pin, software; source must assert.
// [RL9] Four comparators, each assigned to an input, with modes and own flag.
// [RL10] Four oversampling filters, each assigned to an input, with completion flag.
// [RL11] A conversion uses the channel's format, measurement mode and input number.
// [RL12] A finished result is written to that input's result register.
// [RL13] A finished result also feeds any comparator or filter using that channel.
// [RL14] After each shared conversion, the lowest waiting request starts next.
// [RL15] Comparator flag sets on a matching new result, holds until cleared.
module multi_sar_adc_control #(
	parameter int NUM_CHANNELS = sar_ctrl_pkg::NUM_CHANNELS,
	parameter int NUM_COMPARATORS = sar_ctrl_pkg::NUM_COMPARATORS,
	parameter int NUM_FILTERS = sar_ctrl_pkg::NUM_FILTERS
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Trigger sources (asynchronous)
	input wire logic [7:0] pwmTrigger,
	input wire logic multiOutputCaptureCompareTimerTrigger,
	input wire logic singleOutputCaptureCompareTimerTrigger,
	input wire logic configurableLogicCellTrigger,
	input wire logic externalTriggerPin,
	input wire logic softwareTrigger,
	// Per-channel configuration
	input wire logic [NUM_CHANNELS*3-1:0] trigSelect,
	input wire logic [NUM_CHANNELS*3-1:0] pwmSelect,
	input wire logic [NUM_CHANNELS-1:0] signedFormat,
	input wire logic [NUM_CHANNELS-1:0] differential,
	// Per-core resolution
	input wire logic [11:0] coreResolution,
	// Analog core handshake
	output logic [2:0] coreStart,
	output logic [4:0] sharedChannel,
	input wire logic [2:0] coreDone,
	input wire logic [35:0] coreData,
	// Results
	output logic [NUM_CHANNELS*16-1:0] results,
	output logic [NUM_CHANNELS-1:0] resultReady,
	// Comparators
	input wire logic [NUM_COMPARATORS*5-1:0] cmpChannel,
	input wire logic [NUM_COMPARATORS*2-1:0] cmpMode,
	input wire logic [NUM_COMPARATORS*16-1:0] cmpLow,
	input wire logic [NUM_COMPARATORS*16-1:0] cmpHigh,
	input wire logic [NUM_COMPARATORS-1:0] cmpClear,
	output logic [NUM_COMPARATORS-1:0] cmpFlag,
	// Oversampling filters
	input wire logic [NUM_FILTERS*5-1:0] filterChannel,
	input wire logic [NUM_FILTERS-1:0] filterClear,
	output logic [NUM_FILTERS*16-1:0] filterResult,
	output logic [NUM_FILTERS-1:0] filterFlag
);
	logic [12:0] trigMeta_reg;
	logic [12:0] trigSync_reg;
	logic [12:0] trigPrev_reg;
	logic [12:0] trigRise;
	logic [NUM_CHANNELS-1:0] request;
	logic [NUM_CHANNELS-1:0] pending_reg;
	logic [NUM_CHANNELS-1:0] doneVec;
	logic [4:0] lowestPending;
	logic anyPending;
	sar_ctrl_pkg::shared_state_t sharedState_reg;
	logic [15:0] newResult [NUM_CHANNELS];

	// Two-stage synchronisers on every trigger input
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			trigMeta_reg <= 13'h0000;
			trigSync_reg <= 13'h0000;
			trigPrev_reg <= 13'h0000;
		end else begin
			trigMeta_reg <= {softwareTrigger, externalTriggerPin, configurableLogicCellTrigger,
				singleOutputCaptureCompareTimerTrigger, multiOutputCaptureCompareTimerTrigger,
				pwmTrigger};
			trigSync_reg <= trigMeta_reg;
			trigPrev_reg <= trigSync_reg;
		end
	end
	// Rising edges only, so a held source starts one conversion
	assign trigRise = trigSync_reg & ~trigPrev_reg;

	// Per-channel trigger selection
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_trig
			logic [2:0] sel;
			assign sel = trigSelect[ch*3 +: 3];
			always_comb begin
				case (sel) // RL7
					sar_ctrl_pkg::TRIG_SOFTWARE: request[ch] = trigRise[12]; // RL8
					sar_ctrl_pkg::TRIG_PWM: request[ch] = trigRise[pwmSelect[ch*3 +: 3]];
					sar_ctrl_pkg::TRIG_MULTI_TIMER: request[ch] = trigRise[8];
					sar_ctrl_pkg::TRIG_SINGLE_TIMER: request[ch] = trigRise[9];
					sar_ctrl_pkg::TRIG_LOGIC_CELL: request[ch] = trigRise[10];
					sar_ctrl_pkg::TRIG_EXT_PIN: request[ch] = trigRise[11];
					default: request[ch] = 1'b0;
				endcase
			end
			// Format per channel settings
			sar_result_format u_fmt (
				.rawData(ch == sar_ctrl_pkg::DEDICATED_CH0 ? coreData[11:0] :
					ch == sar_ctrl_pkg::DEDICATED_CH1 ? coreData[23:12] : coreData[35:24]),
				.resolution(ch == sar_ctrl_pkg::DEDICATED_CH0 ? coreResolution[3:0] :
					ch == sar_ctrl_pkg::DEDICATED_CH1 ? coreResolution[7:4] :
					coreResolution[11:8]), // RL2
				.signedFormat(signedFormat[ch]), // RL4
				.differential(differential[ch]), // RL11
				.formatted(newResult[ch])
			);
		end
	endgenerate

	// Lowest-numbered waiting shared input
	always_comb begin
		lowestPending = 5'h00;
		anyPending = 1'b0;
		for (int i = NUM_CHANNELS - 1; i >= 2; i--) begin
			if (pending_reg[i]) begin
				lowestPending = 5'(i); // RL6
				anyPending = 1'b1;
			end
		end
	end

	// Completion per channel: dedicated cores own inputs 0 and 1
	always_comb begin
		doneVec = '0;
		doneVec[sar_ctrl_pkg::DEDICATED_CH0] = coreDone[0]; // RL1
		doneVec[sar_ctrl_pkg::DEDICATED_CH1] = coreDone[1];
		if (coreDone[2] && sharedState_reg == sar_ctrl_pkg::SH_BUSY) begin
			doneVec[sharedChannel] = 1'b1;
		end
	end

	// Pending shared requests; a new trigger wins over the start clearing it
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pending_reg <= '0;
		end else begin
			pending_reg <= (pending_reg & ~((sharedState_reg == sar_ctrl_pkg::SH_IDLE && anyPending)
				? (NUM_CHANNELS'(1) << lowestPending) : '0)) | (request & ~NUM_CHANNELS'(3));
		end
	end

	// Shared core sequencer and dedicated core starts
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sharedState_reg <= sar_ctrl_pkg::SH_IDLE;
			sharedChannel <= 5'h00;
			coreStart <= 3'h0;
		end else begin
			coreStart[0] <= request[sar_ctrl_pkg::DEDICATED_CH0]; // RL5
			coreStart[1] <= request[sar_ctrl_pkg::DEDICATED_CH1];
			coreStart[2] <= 1'b0;
			case (sharedState_reg)
				sar_ctrl_pkg::SH_IDLE: begin
					if (anyPending) begin
						sharedChannel <= lowestPending; // RL6
						coreStart[2] <= 1'b1;
						sharedState_reg <= sar_ctrl_pkg::SH_BUSY;
					end
				end
				sar_ctrl_pkg::SH_BUSY: begin
					if (coreDone[2]) begin
						sharedState_reg <= sar_ctrl_pkg::SH_IDLE; // RL14
					end
				end
				default: sharedState_reg <= sar_ctrl_pkg::SH_IDLE;
			endcase
		end
	end

	// Result registers per channel
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				results[i*16 +: 16] <= sar_ctrl_pkg::RESULT_RESET;
			end
			resultReady <= '0;
		end else begin
			resultReady <= doneVec;
			for (int i = 0; i < NUM_CHANNELS; i++) begin
				if (doneVec[i]) begin
					results[i*16 +: 16] <= newResult[i]; // RL3 RL12
				end
			end
		end
	end

	// Comparators watch their channel's fresh result
	genvar c;
	generate
		for (c = 0; c < NUM_COMPARATORS; c++) begin : g_cmp
			logic [4:0] chSel;
			logic [15:0] value;
			logic hit;
			assign chSel = cmpChannel[c*5 +: 5];
			assign value = newResult[chSel]; // RL13
			always_comb begin
				case (sar_ctrl_pkg::cmp_mode_t'(cmpMode[c*2 +: 2])) // RL9
					sar_ctrl_pkg::CMP_ABOVE: hit = value >= cmpHigh[c*16 +: 16];
					sar_ctrl_pkg::CMP_BELOW: hit = value < cmpLow[c*16 +: 16];
					sar_ctrl_pkg::CMP_INSIDE: hit = value >= cmpLow[c*16 +: 16] &&
						value < cmpHigh[c*16 +: 16];
					sar_ctrl_pkg::CMP_OUTSIDE: hit = value < cmpLow[c*16 +: 16] ||
						value >= cmpHigh[c*16 +: 16];
					default: hit = 1'b0;
				endcase
			end
			// Set wins over a clear in the same cycle
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					cmpFlag[c] <= 1'b0;
				end else if (chSel < NUM_CHANNELS && doneVec[chSel] && hit) begin
					cmpFlag[c] <= 1'b1; // RL15
				end else if (cmpClear[c]) begin
					cmpFlag[c] <= 1'b0;
				end
			end
		end
	endgenerate

	// Oversampling filters: sum 4 samples, result gains one bit
	genvar f;
	generate
		for (f = 0; f < NUM_FILTERS; f++) begin : g_flt
			logic [4:0] chSel;
			logic [17:0] acc_reg;
			logic [1:0] count_reg;
			logic [17:0] sum;
			assign chSel = filterChannel[f*5 +: 5];
			assign sum = acc_reg + {2'h0, newResult[chSel]};
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					acc_reg <= 18'h00000;
					count_reg <= 2'h0;
					filterResult[f*16 +: 16] <= sar_ctrl_pkg::RESULT_RESET;
					filterFlag[f] <= 1'b0;
				end else begin
					if (chSel < NUM_CHANNELS && doneVec[chSel]) begin // RL13
						count_reg <= count_reg + 2'h1;
						if (count_reg == 2'h3) begin
							filterResult[f*16 +: 16] <= sum[16:1]; // RL10
							filterFlag[f] <= 1'b1;
							acc_reg <= 18'h00000;
						end else begin
							acc_reg <= sum;
							if (filterClear[f]) begin
								filterFlag[f] <= 1'b0;
							end
						end
					end else if (filterClear[f]) begin
						filterFlag[f] <= 1'b0;
					end
				end
			end
		end
	endgenerate
endmodule

// ---- dv/analog_core_model.sv ----
// Behavioural model of the three analog cores answering start pulses
module analog_core_model #(
	parameter int LAT = 4
) (
	// Core handshake
	input wire logic sys_clk,
	input wire logic [2:0] coreStart,
	input wire logic [4:0] sharedChannel,
	output logic [2:0] coreDone = 3'h0,
	output logic [35:0] coreData = 36'h0
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt [3] = '{0, 0, 0};
	logic [4:0] chan [3];

	// Lane toggles outside done, so a stale word never passes for a result
	always @(posedge sys_clk) begin
		for (int k = 0; k < 3; k++) begin
			coreDone[k] <= cnt[k] == 1;
			coreData[k*12 +: 12] <= (cnt[k] == 1) ? {2'b10, chan[k], 5'h0A} : ~coreData[k*12 +: 12];
			if (coreStart[k]) begin
				cnt[k] <= LAT;
				chan[k] <= (k == 2) ? sharedChannel : 5'(k);
			end else if (cnt[k] != 0) begin
				cnt[k] <= cnt[k] - 1;
			end
		end
	end
endmodule

// ---- dv/multi_sar_adc_control_monitor.sv ----
// Concurrent checks on the converter control ports
module multi_sar_adc_control_monitor #(
	parameter int NUM_CHANNELS = 24,
	parameter int NUM_COMPARATORS = 4
) (
	// Watched ports
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic [2:0] coreStart,
	input wire logic [4:0] sharedChannel,
	input wire logic [2:0] coreDone,
	input wire logic [35:0] coreData,
	input wire logic [NUM_CHANNELS*16-1:0] results,
	input wire logic [NUM_CHANNELS-1:0] resultReady,
	input wire logic [NUM_CHANNELS-1:0] signedFormat,
	input wire logic [NUM_CHANNELS-1:0] differential,
	input wire logic [11:0] coreResolution,
	input wire logic [NUM_COMPARATORS*5-1:0] cmpChannel,
	input wire logic [NUM_COMPARATORS-1:0] cmpClear,
	input wire logic [NUM_COMPARATORS-1:0] cmpFlag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_shared_gap: assert property (coreDone[2] |-> !coreStart[2] ##1 !coreStart[2])
		else $error("shared start too soon after done");
	a_shared_hold: assert property (coreStart[2] |=> !coreStart[2] [*4])
		else $error("shared start while busy");
	a_shared_ready: assert property (coreDone[2] |=> resultReady[$past(sharedChannel)])
		else $error("shared result not posted to its channel");
	a_shared_range: assert property (coreStart[2] |-> sharedChannel >= 5'h02)
		else $error("dedicated channel sent to shared core");
	a_ded_result: assert property (coreDone[0] && !signedFormat[0] && !differential[0]
		&& coreResolution[3:0] >= 4'hC |=> results[15:0] == {4'h0, $past(coreData[11:0])})
		else $error("unsigned result mismatch");
	a_ded_signed: assert property (coreDone[1] && signedFormat[1] && coreResolution[7:4] >= 4'hC
		|=> results[31:16] == {{5{~$past(coreData[23])}}, $past(coreData[22:12])})
		else $error("signed result mismatch");
	a_ded_ready: assert property (coreDone[1] |=> resultReady[1])
		else $error("dedicated result not ready");
	a_ready_cause: assert property (resultReady[0] |-> $past(coreDone[0]))
		else $error("result ready without conversion");
	a_cmp_sticky: assert property (cmpFlag[0] && !cmpClear[0] |=> cmpFlag[0])
		else $error("comparator flag dropped");
	a_cmp_cause: assert property ($rose(cmpFlag[0]) |-> resultReady[cmpChannel[4:0]])
		else $error("comparator flag without new result");

	c_shared: cover property (coreStart[2] ##[1:20] coreStart[2]);
	c_flag: cover property ($rose(cmpFlag[0]));
	c_both: cover property (resultReady[0] && resultReady[1]);
endmodule

bind multi_sar_adc_control multi_sar_adc_control_monitor #(.NUM_CHANNELS(NUM_CHANNELS),
	.NUM_COMPARATORS(NUM_COMPARATORS)) i_monitor (.sys_clk(sys_clk), .reset(reset),
	.coreStart(coreStart), .sharedChannel(sharedChannel), .coreDone(coreDone),
	.coreData(coreData), .results(results), .resultReady(resultReady),
	.signedFormat(signedFormat), .differential(differential), .coreResolution(coreResolution),
	.cmpChannel(cmpChannel), .cmpClear(cmpClear), .cmpFlag(cmpFlag));

// ---- dv/tb.sv ----
// Self-checking bench for the converter control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [6:1] trig = 6'h00;
	logic [71:0] trigSelect = 72'h0;
	logic [71:0] pwmSelect = 72'h0;
	logic [23:0] signedFormat = 24'h0;
	logic [23:0] differential = 24'h0;
	logic [2:0] coreStart, coreDone;
	logic [4:0] sharedChannel;
	logic [35:0] coreData;
	logic [383:0] results;
	logic [23:0] resultReady, seen;
	logic [19:0] cmpChannel = 20'h0;
	logic [7:0] cmpMode = 8'h00;
	logic [63:0] cmpLow = 64'h0, cmpHigh = 64'h0, filterResult;
	logic [3:0] cmpClear = 4'h0, cmpFlag, filterFlag;
	logic [3:0] filterClear = 4'h0;
	logic [11:0] coreResolution = 12'hCCC;
	logic [4:0] order [$];
	int fail_count = 0;
	int check_count = 0;

	multi_sar_adc_control i_multi_sar_adc_control (.sys_clk(sys_clk), .reset(reset),
		.pwmTrigger({3'h0, trig[2], 4'h0}), .multiOutputCaptureCompareTimerTrigger(trig[3]),
		.singleOutputCaptureCompareTimerTrigger(trig[4]), .configurableLogicCellTrigger(trig[5]),
		.externalTriggerPin(trig[6]), .softwareTrigger(trig[1]), .trigSelect(trigSelect),
		.pwmSelect(pwmSelect), .signedFormat(signedFormat), .differential(differential),
		.coreResolution(coreResolution), .coreStart(coreStart), .sharedChannel(sharedChannel),
		.coreDone(coreDone), .coreData(coreData), .results(results), .resultReady(resultReady),
		.cmpChannel(cmpChannel), .cmpMode(cmpMode), .cmpLow(cmpLow), .cmpHigh(cmpHigh),
		.cmpClear(cmpClear), .cmpFlag(cmpFlag), .filterChannel(20'h00003),
		.filterClear(filterClear),
		.filterResult(filterResult), .filterFlag(filterFlag));
	analog_core_model i_analog_core_model (.sys_clk(sys_clk), .coreStart(coreStart),
		.sharedChannel(sharedChannel), .coreDone(coreDone), .coreData(coreData));

	// Clock and watchdog, well beyond the few hundred cycles of the run
	initial forever #5 sys_clk = ~sys_clk;
	initial begin
		#200us;
		fail_count++;
		tally_and_finish();
	end
	// Sticky record of ready pulses and of shared start order
	always @(posedge sys_clk) seen <= seen | resultReady;
	always @(posedge sys_clk) if (coreStart[2] === 1'b1) order.push_back(sharedChannel);

	function automatic logic [15:0] expect16(input logic [4:0] ch, input logic sgn);
		logic [11:0] s;
		s = {2'b10, ch, 5'h0A};
		return sgn ? {{5{~s[11]}}, s[10:0]} : {4'h0, s};
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// Source held a few cycles so the synchroniser sees one clean rise
	task automatic fire(input int code);
		seen = '0;
		trig[code] = 1'b1;
		step(3);
		trig[code] = 1'b0;
	endtask

	task automatic wait_seen(input logic [23:0] mask);
		int n;
		n = 0;
		while ((seen & mask) !== mask && n < 200) begin
			step(1);
			n++;
		end
		check(16'((seen & mask) === mask), 16'h0001);
	endtask

	task automatic test_dedicated();
		trigSelect[5:0] = {2{sar_ctrl_pkg::TRIG_SOFTWARE}};
		signedFormat[1] = 1'b1;
		fire(1);
		wait_seen(24'h3);
		check(results[15:0], expect16(5'h00, 1'b0));
		check(results[31:16], expect16(5'h01, 1'b1));
		trigSelect[5:0] = 6'h00;
	endtask

	task automatic test_sources();
		for (int c = 1; c <= 6; c++) trigSelect[(c+1)*3 +: 3] = 3'(c);
		trigSelect[26:24] = 3'h7;
		pwmSelect[11:9] = 3'h4;
		differential[5] = 1'b1;
		for (int c = 1; c <= 6; c++) begin
			fire(c);
			wait_seen(24'h1 << (c + 1));
			step(10);
			check(seen[15:0], 16'h1 << (c + 1));
			check(results[(c+1)*16 +: 16], expect16(5'(c + 1), c == 4));
		end
	endtask

	task automatic test_order();
		for (int c = 2; c <= 7; c++) trigSelect[c*3 +: 3] = sar_ctrl_pkg::TRIG_SOFTWARE;
		order.delete();
		fire(1);
		wait_seen(24'hFC);
		check(16'(order.size()), 16'h0006);
		for (int i = 0; i < order.size(); i++) check(16'(order[i]), 16'(i + 2));
	endtask

	task automatic test_compare();
		logic [15:0] e;
		e = expect16(5'h03, 1'b0);
		cmpChannel = {4{5'h03}};
		cmpMode = {sar_ctrl_pkg::CMP_OUTSIDE, sar_ctrl_pkg::CMP_INSIDE,
			sar_ctrl_pkg::CMP_BELOW, sar_ctrl_pkg::CMP_ABOVE};
		cmpLow = {e, e, e, 16'h0};
		cmpHigh = {e + 16'h1, e + 16'h1, 16'h0, e};
		// Flags still hold hits from the all-zero setup of earlier tests
		cmpClear = 4'hF;
		step(1);
		cmpClear = 4'h0;
		check({12'h0, cmpFlag}, 16'h0000);
		fire(1);
		wait_seen(24'hFC);
		check({12'h0, cmpFlag}, 16'h0005);
		cmpClear = 4'hF;
		step(1);
		cmpClear = 4'h0;
		check({12'h0, cmpFlag}, 16'h0000);
		fire(1);
		wait_seen(24'hFC);
		check({12'h0, cmpFlag}, 16'h0005);
		check({15'h0, filterFlag[0]}, 16'h0001);
		// Four equal samples summed and halved give twice one sample
		check(filterResult[15:0], 16'(e << 1));
		filterClear = 4'h1;
		step(1);
		filterClear = 4'h0;
		check({15'h0, filterFlag[0]}, 16'h0000);
	endtask

	// Shared core cut to 8 bits: the low four result bits read as zero
	task automatic test_resolution();
		coreResolution = 12'h8CC;
		fire(1);
		wait_seen(24'hFC);
		check(results[47:32], expect16(5'h02, 1'b0) & 16'hFFF0);
		coreResolution = 12'hCCC;
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		step(5);
		reset = 1'b0;
		check({12'h0, cmpFlag}, 16'h0000);
		check(resultReady[15:0], 16'h0000);
		test_dedicated();
		test_sources();
		test_order();
		test_compare();
		test_resolution();
		tally_and_finish();
	end
endmodule
